//--- common/status_agg_consts.vh
// bit positions and widths for the interrupt status aggregator
`ifndef STATUS_AGG_CONSTS_VH
`define STATUS_AGG_CONSTS_VH

`define REG_W           32
`define BIT_DEVICE      31
`define BIT_LOAD_FAIL   29
`define BIT_LOAD_ERR    28
`define BIT_MANUAL_RDY  27
`define LOSLMT_HI       25
`define LOSLMT_LO       21
`define BIT_LOL_LMT     19
`define FREQ_HI         17
`define FREQ_LO         14
`define LOS_HI          8
`define LOS_LO          4
`define BIT_LOL         0
`define GPO_N           4
`define GPO_SEL_W       2
`define STATUS_RESET    32'h0000_0000
`define EN_RESET        32'h0000_0000
`define SRC_MASK        32'h3beb_c1f1

`endif

//--- rtl/flag_collect.v
// gathers raw event bits into the status word layout
`timescale 1ns/10ps
`default_nettype none

module flag_collect (
	// events
	input  wire        otp_load_fail_i,
	input  wire        prom_load_fail_i,
	input  wire        otp_crc_err_i,
	input  wire        prom_crc_err_i,
	input  wire        manual_rdy_i,
	input  wire [4:0]  loss_limit_i,
	input  wire        lol_limit_i,
	input  wire [3:0]  frequency_i,
	input  wire [4:0]  loss_i,
	input  wire        lol_i,
	// result
	output wire [31:0] flags_o
);

	// *****************************************
	// bit mapping
	// *****************************************
	// reserved positions stay zero
	assign flags_o = {
		1'b0,                               // device bit filled later
		1'b0,
		otp_load_fail_i | prom_load_fail_i,
		otp_crc_err_i | prom_crc_err_i,
		manual_rdy_i,
		1'b0,
		loss_limit_i,
		1'b0,
		lol_limit_i,
		1'b0,
		frequency_i,
		5'h00,
		loss_i,
		3'h0,
		lol_i
	};

endmodule // flag_collect

`default_nettype wire

//--- rtl/interrupt_status_aggregator.v
// interrupt status register, masking and gpio routing for the clock core
`timescale 1ns/10ps
`default_nettype none
`include "status_agg_consts.vh"

module interrupt_status_aggregator (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// event sources
	input  wire        otp_load_fail_i,
	input  wire        prom_load_fail_i,
	input  wire        otp_crc_err_i,
	input  wire        prom_crc_err_i,
	input  wire        manual_rdy_i,
	input  wire [4:0]  loss_limit_i,
	input  wire        lol_limit_i,
	input  wire [3:0]  frequency_i,
	input  wire [4:0]  loss_i,
	input  wire        lol_i,
	// enable word from the register file
	input  wire [31:0] int_enable_i,
	// gpio routing
	input  wire        gpo_route_en_i,
	input  wire [1:0]  gpo_sel_i,
	// outputs
	output reg  [31:0] interrupt_status_o,
	output reg         device_int_o,
	output reg  [3:0]  gpo_int_o
);

	// *****************************************
	// local constants
	// *****************************************
	localparam [31:0] SRC_MASK_W = `SRC_MASK;
	localparam [31:0] STATUS_RST = `STATUS_RESET;
	localparam [3:0]  GPO_IDLE   = 4'h0;
	localparam [0:0]  FLAG_CLR   = 1'b0;

	// *****************************************
	// internal signals
	// *****************************************
	wire [31:0] flags;
	wire [30:0] src_flags;
	wire        load_fail_flag;
	wire        load_err_flag;
	wire        manual_flag;
	wire [4:0]  loss_limit_flags;
	wire        lol_limit_flag;
	wire [3:0]  frequency_flags;
	wire [4:0]  loss_flags;
	wire        lol_flag;
	wire        global_enable;
	wire        load_hit;
	wire        manual_hit;
	wire        loss_limit_hit;
	wire        lol_limit_hit;
	wire        frequency_hit;
	wire        loss_hit;
	wire        lol_hit;
	wire        any_hit;
	wire        next_overall;
	reg  [31:0] next_status;
	reg  [3:0]  next_gpo;

	// *****************************************
	// helpers
	// *****************************************
	// masked OR over one field; the mask also drops enable bits at reserved positions
	function field_hit;
		input [31:0]  word;
		input [31:0]  enable;
		input integer hi;
		input integer lo;
		integer       b;
		begin
			field_hit = 1'b0;
			for (b = lo; b <= hi; b = b + 1) begin
				field_hit = field_hit | (word[b] & enable[b] & SRC_MASK_W[b]);
			end
		end
	endfunction

	// one-hot pin pick; unselected pins held low
	function [3:0] pin_pick;
		input       route;
		input [1:0] sel;
		input       level;
		integer     p;
		begin
			pin_pick = GPO_IDLE;
			for (p = 0; p < `GPO_N; p = p + 1) begin
				if (route && (sel == p[`GPO_SEL_W-1:0])) begin
					pin_pick[p] = level;
				end
			end
		end
	endfunction

	// *****************************************
	// source collection
	// *****************************************
	flag_collect u_collect (
		.otp_load_fail_i  (otp_load_fail_i),
		.prom_load_fail_i (prom_load_fail_i),
		.otp_crc_err_i    (otp_crc_err_i),
		.prom_crc_err_i   (prom_crc_err_i),
		.manual_rdy_i     (manual_rdy_i),
		.loss_limit_i     (loss_limit_i),
		.lol_limit_i      (lol_limit_i),
		.frequency_i      (frequency_i),
		.loss_i           (loss_i),
		.lol_i            (lol_i),
		.flags_o          (flags)
	);

	// *****************************************
	// status word
	// *****************************************
	assign src_flags = flags[`BIT_DEVICE-1:0] & SRC_MASK_W[`BIT_DEVICE-1:0];

	assign load_fail_flag   = src_flags[`BIT_LOAD_FAIL];
	assign load_err_flag    = src_flags[`BIT_LOAD_ERR];
	assign manual_flag      = src_flags[`BIT_MANUAL_RDY];
	assign loss_limit_flags = src_flags[`LOSLMT_HI:`LOSLMT_LO];
	assign lol_limit_flag   = src_flags[`BIT_LOL_LMT];
	assign frequency_flags  = src_flags[`FREQ_HI:`FREQ_LO];
	assign loss_flags       = src_flags[`LOS_HI:`LOS_LO];
	assign lol_flag         = src_flags[`BIT_LOL];

	// reserved positions keep the reset pattern, so they read zero
	always @* begin
		next_status                        = STATUS_RST;
		next_status[`BIT_LOAD_FAIL]        = load_fail_flag;
		next_status[`BIT_LOAD_ERR]         = load_err_flag;
		next_status[`BIT_MANUAL_RDY]       = manual_flag;
		next_status[`LOSLMT_HI:`LOSLMT_LO] = loss_limit_flags;
		next_status[`BIT_LOL_LMT]          = lol_limit_flag;
		next_status[`FREQ_HI:`FREQ_LO]     = frequency_flags;
		next_status[`LOS_HI:`LOS_LO]       = loss_flags;
		next_status[`BIT_LOL]              = lol_flag;
		next_status[`BIT_DEVICE]           = next_overall;
	end

	// *****************************************
	// overall flag
	// *****************************************
	assign load_hit       = field_hit(flags, int_enable_i,
		`BIT_LOAD_FAIL, `BIT_LOAD_ERR);
	assign manual_hit     = field_hit(flags, int_enable_i,
		`BIT_MANUAL_RDY, `BIT_MANUAL_RDY);
	assign loss_limit_hit = field_hit(flags, int_enable_i,
		`LOSLMT_HI, `LOSLMT_LO);
	assign lol_limit_hit  = field_hit(flags, int_enable_i,
		`BIT_LOL_LMT, `BIT_LOL_LMT);
	assign frequency_hit  = field_hit(flags, int_enable_i,
		`FREQ_HI, `FREQ_LO);
	assign loss_hit       = field_hit(flags, int_enable_i,
		`LOS_HI, `LOS_LO);
	assign lol_hit        = field_hit(flags, int_enable_i,
		`BIT_LOL, `BIT_LOL);

	assign any_hit = load_hit
		| manual_hit
		| loss_limit_hit
		| lol_limit_hit
		| frequency_hit
		| loss_hit
		| lol_hit;

	// global enable gates last so a masked source never leaks onto the pin
	assign global_enable = int_enable_i[`BIT_DEVICE];
	assign next_overall  = any_hit & global_enable;

	// *****************************************
	// pin routing
	// *****************************************
	always @* begin
		next_gpo = pin_pick(gpo_route_en_i, gpo_sel_i, next_overall);
	end

	// *****************************************
	// registers
	// *****************************************
	// no write path exists, so software cannot disturb the flags
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			interrupt_status_o <= STATUS_RST;
		end else begin
			interrupt_status_o <= next_status;
		end
	end

	// pin and bit 31 share one source, so they never disagree
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			device_int_o <= FLAG_CLR;
		end else begin
			device_int_o <= next_overall;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gpo_int_o <= GPO_IDLE;
		end else begin
			gpo_int_o <= next_gpo;
		end
	end

endmodule // interrupt_status_aggregator

`default_nettype wire

//--- sim/host_model.sv
// host that reads the status word while its interrupt pin is raised
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic        clk_i, pin_i,
	input wire logic [31:0] status_i,
	output var logic [31:0] seen_o
);
	// a quiet pin leaves the last read alone, as a polling-free host would
	always @(posedge clk_i) if (pin_i) seen_o <= status_i;
endmodule // host_model
`default_nettype wire

//--- sim/status_agg_monitor.sv
// port checker for the interrupt status aggregator
`timescale 1ns/10ps
`default_nettype none
module status_agg_monitor (
	// single-bit ports
	input wire logic clk_i, rst_i, otp_load_fail_i, prom_load_fail_i, otp_crc_err_i, prom_crc_err_i,
	input wire logic manual_rdy_i, lol_limit_i, lol_i, gpo_route_en_i, device_int_o,
	// vectors
	input wire logic [4:0]  loss_limit_i, loss_i,
	input wire logic [3:0]  frequency_i, gpo_int_o,
	input wire logic [1:0]  gpo_sel_i,
	input wire logic [31:0] int_enable_i, interrupt_status_o
);
	logic      up; // first edge after reset still sees stale inputs
	wire [31:0] s = interrupt_status_o;
	wire [31:0] e = int_enable_i;
	always_ff @(posedge clk_i or posedge rst_i) up <= !rst_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_top_flag: assert property (up |-> s[31] == ($past(e[31]) & |(s[30:0] & $past(e[30:0]))))
		else $error("top flag");
	a_pin_follow: assert property (device_int_o == s[31])
		else $error("pin");
	a_gpo_route: assert property (up |-> gpo_int_o ==
		(({3'h0, $past(gpo_route_en_i)} << $past(gpo_sel_i)) & {4{device_int_o}})) else $error("gpo");
	a_load_flags: assert property (up |-> s[29:28] ==
		{$past(otp_load_fail_i) | $past(prom_load_fail_i),
		$past(otp_crc_err_i) | $past(prom_crc_err_i)}) else $error("load");
	a_mid_copy: assert property (up |-> s[27:19] ==
		{$past(manual_rdy_i), 1'h0, $past(loss_limit_i), 1'h0, $past(lol_limit_i)}) else $error("mid");
	a_freq_copy: assert property (up |-> s[17:14] == $past(frequency_i))
		else $error("freq");
	a_loss_copy: assert property (up |-> {s[8:4], s[0]} == {$past(loss_i), $past(lol_i)})
		else $error("loss");
	a_reserved_zero: assert property ((s & 32'h4414_3e0e) == 32'h0)
		else $error("reserved");
endmodule // status_agg_monitor
bind interrupt_status_aggregator status_agg_monitor mon_u (.clk_i, .rst_i, .otp_load_fail_i, .prom_load_fail_i,
	.otp_crc_err_i, .prom_crc_err_i, .manual_rdy_i, .lol_limit_i, .lol_i, .gpo_route_en_i, .device_int_o,
	.loss_limit_i, .loss_i, .frequency_i, .gpo_int_o, .gpo_sel_i, .int_enable_i, .interrupt_status_o);
`default_nettype wire

//--- sim/test_interrupt_status_aggregator.sv
// self-checking bench for the interrupt status aggregator
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_status_aggregator;
	logic        clk_i = 0, rst_i = 1, re = 0, pin;
	logic [1:0]  sl = 0;
	logic [20:0] v = '1; // packed sources, msb is the fuse load failure
	logic [31:0] en = '1, st;
	logic [3:0]  g;
	logic [31:0] seen;
	int          fails = 0, checks = 0, cyc = 0;
	always #2.5 clk_i = ~clk_i;
	interrupt_status_aggregator dut_u (.clk_i, .rst_i, .otp_load_fail_i(v[20]), .prom_load_fail_i(v[19]),
		.otp_crc_err_i(v[18]), .prom_crc_err_i(v[17]), .manual_rdy_i(v[16]), .loss_limit_i(v[15:11]),
		.lol_limit_i(v[10]), .frequency_i(v[9:6]), .loss_i(v[5:1]), .lol_i(v[0]), .int_enable_i(en),
		.gpo_route_en_i(re), .gpo_sel_i(sl), .interrupt_status_o(st), .device_int_o(pin), .gpo_int_o(g));
	host_model host_u (.clk_i, .pin_i(pin), .status_i(st), .seen_o(seen));
	task cmp(string n, logic [31:0] x, logic [31:0] y);
		checks++;
		if (x !== y) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, x, y);
		end
	endtask
	function logic [31:0] model(logic [20:0] a, logic [31:0] e);
		logic [31:0] s;
		s = {2'h0, a[20] | a[19], a[18] | a[17], a[16], 1'h0, a[15:11], 1'h0, a[10], 1'h0, a[9:6], 5'h0, a[5:1], 3'h0, a[0]};
		s[31] = e[31] & |(s[30:0] & e[30:0]);
		return s;
	endfunction
	task run(logic [20:0] a, logic [31:0] e, logic r, logic [1:0] k);
		logic [31:0] x;
		v = a;
		en = e;
		re = r;
		sl = k;
		@(negedge clk_i);
		x = model(a, e);
		cmp("status", x, st);
		cmp("pin", {31'h0, x[31]}, {31'h0, pin});
		cmp("gpo", {28'h0, r ? 4'h1 << k & {4{x[31]}} : 4'h0}, {28'h0, g});
	endtask
	task t_masks;
		for (int i = 0; i < 21; i++) begin
			run(21'h1 << i, 32'h7fff_ffff, 1, 2);
			run(21'h1 << i, 32'h8000_0000 | model(21'h1 << i, 0), 1, 3);
			run(21'h1 << i, ~model(21'h1 << i, 0), 0, 1);
		end
		run('1, 32'hc414_3e0e, 1, 0);
		$display("mask test done");
	endtask
	task t_routing;
		for (int k = 0; k < 4; k++) begin
			run(21'h1, '1, 1, k[1:0]);
			run(21'h0, '1, 1, k[1:0]);
		end
		run(21'h1, '1, 0, 2);
		cmp("host", 32'h8000_0001, seen);
		$display("routing test done");
	endtask
	task complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// the whole run needs about 93 cycles
	always @(posedge clk_i) if (++cyc == 1000) begin
		fails++;
		complete_run;
	end
	initial begin
		repeat (20) @(negedge clk_i);
		cmp("reset", 32'h0, st);
		cmp("reset pins", 32'h0, {27'h0, pin, g});
		rst_i = 0;
		t_masks;
		t_routing;
		complete_run;
	end
endmodule // test_interrupt_status_aggregator
`default_nettype wire
